// file: hw/psf_check.v
// Combinational permission check indexed by the doubled initiator tag
`timescale 1ns/10ps
`include "psf_consts.vh"
module psf_check (
  // Tag in
  input  wire [`PSF_TAG_W-1:0]   initiatorTag,
  // Membership
  input  wire [31:0]             memberMask,
  // Result
  output wire [`PSF_FWTAG_W-1:0] fwTag,
  output wire                    grant
);
  assign fwTag = {initiatorTag, 1'b0};
  assign grant = memberMask[fwTag];
endmodule

// file: hw/psf_consts.vh
// Constants for the peripheral segment firewall with shifted initiator tags
// Functional notes
// - Segment firewall receives initiator tag shifted left one bit versus other segments
// - Permission lookup indexes the membership vector with the doubled tag
// - Violations log the offending initiator using the doubled tag value
// - Reset membership mask has its upper sixteen bits zero
// - Out of reset initiators with tag eight or more are denied
// - Standard tag n, 0 to C, maps to firewall tag and bit 2n
`ifndef PSF_CONSTS_VH
`define PSF_CONSTS_VH
`define PSF_ADDR_MASK      8'h00
`define PSF_ADDR_STATUS    8'h04
`define PSF_ADDR_LOG       8'h08
`define PSF_ADDR_COUNT     8'h0c
`define PSF_ADDR_LOGADDR   8'h10
`define PSF_MASK_RESET     32'h0000ffff
`define PSF_TAG_W          4
`define PSF_FWTAG_W        5
`define PSF_STAT_VALID     0
`define PSF_STAT_OVERRUN   1
`endif

// file: hw/psf_firewall.v
// Peripheral segment firewall: APB registers, access check and error log
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "psf_consts.vh"
module psf_firewall (
  // Clock and reset
  input  wire                  sys_clk,
  input  wire                  rst_b,
  // APB slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [7:0]            paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  // Initiator access request
  input  wire                  accValid,
  input  wire [`PSF_TAG_W-1:0] initiatorTag,
  input  wire                  accWrite,
  input  wire [31:0]           accAddr,
  // Access answer
  output reg                   accDone_r,
  output reg                   accGrant_r,
  output reg                   accError_r
);
  wire        rstSync;
  reg  [31:0] groupMemberMask_r;
  reg         logValid_r;
  reg         logOverrun_r;
  reg  [`PSF_FWTAG_W-1:0] logTag_r;
  reg         logWrite_r;
  reg  [31:0] logAddr_r;
  reg  [15:0] violCount_r;
  reg  [31:0] rdNxt;
  reg         errNxt;
  wire [`PSF_FWTAG_W-1:0] fwTag;
  wire        grant;
  wire        apbAcc;
  wire        apbWr;
  wire        apbRd;
  wire        viol;
  wire        clrLog;

  // Reset release through two flops
  psf_sync uRstSync (
    .clk  (sys_clk),
    .rstB (rst_b),
    .d    (1'b1),
    .q    (rstSync)
  );

  psf_check uCheck (
    .initiatorTag (initiatorTag),
    .memberMask   (groupMemberMask_r),
    .fwTag        (fwTag),
    .grant        (grant)
  );

  assign apbAcc = psel && penable && !pready;
  assign apbWr  = apbAcc && pwrite;
  assign apbRd  = apbAcc && !pwrite;
  assign viol   = accValid && !grant;
  assign clrLog = apbWr && (paddr == `PSF_ADDR_STATUS) && pwdata[`PSF_STAT_VALID];

  // Read mux and unmapped decode
  always @* begin
    rdNxt  = 32'h0000_0000;
    errNxt = 1'b0;
    case (paddr)
      `PSF_ADDR_MASK:   rdNxt = groupMemberMask_r;
      `PSF_ADDR_STATUS: rdNxt = {30'h0000_0000, logOverrun_r, logValid_r};
      `PSF_ADDR_LOG:    rdNxt = {23'h00_0000, logWrite_r, 3'h0, logTag_r};
      `PSF_ADDR_COUNT:  rdNxt = {16'h0000, violCount_r};
      `PSF_ADDR_LOGADDR: rdNxt = logAddr_r;
      default:          errNxt = 1'b1;
    endcase
  end

  // APB answer: one wait state
  always @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbAcc;
      pslverr <= apbAcc && errNxt;
      if (apbRd) begin
        prdata <= rdNxt;
      end
    end
  end

  // Membership mask; only low half admitted out of reset
  always @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      groupMemberMask_r <= `PSF_MASK_RESET;
    end else if (apbWr && (paddr == `PSF_ADDR_MASK)) begin
      groupMemberMask_r <= pwdata;
    end
  end

  // Access answer and violation log; a new violation wins over a clear
  always @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      accDone_r    <= 1'b0;
      accGrant_r   <= 1'b0;
      accError_r   <= 1'b0;
      logValid_r   <= 1'b0;
      logOverrun_r <= 1'b0;
      logTag_r     <= {`PSF_FWTAG_W{1'b0}};
      logWrite_r   <= 1'b0;
      logAddr_r    <= 32'h0000_0000;
      violCount_r  <= 16'h0000;
    end else begin
      accDone_r  <= accValid;
      accGrant_r <= accValid && grant;
      accError_r <= viol;
      if (viol) begin
        if (violCount_r != 16'hffff) begin
          violCount_r <= violCount_r + 16'h0001;
        end
        if (!logValid_r || clrLog) begin
          logValid_r <= 1'b1;
          logTag_r   <= fwTag;
          logWrite_r <= accWrite;
          logAddr_r  <= accAddr;
        end else begin
          logOverrun_r <= 1'b1;
        end
        if (clrLog) begin
          logOverrun_r <= 1'b0;
        end
      end else if (clrLog) begin
        logValid_r   <= 1'b0;
        logOverrun_r <= 1'b0;
      end
    end
  end
endmodule

// file: hw/psf_sync.v
// Two-flop synchroniser for one level
`timescale 1ns/10ps
module psf_sync (
  // Clock and reset
  input  wire clk,
  input  wire rstB,
  // Data
  input  wire d,
  output reg  q
);
  reg stage1;
  always @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      stage1 <= 1'b0;
      q      <= 1'b0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule

// file: testbench/psf_asserts.sv
// Port timing checks for the firewall
`timescale 1ns/10ps
module psf_asserts (
  input wire       sys_clk, rst_b, psel, penable, pwrite, pready, pslverr,
  input wire       accValid, accDone_r, accGrant_r, accError_r,
  input wire [3:0] initiatorTag
);
  reg  wrote_r;
  wire fresh = accValid && !wrote_r;
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b) wrote_r <= 1'b0;
    else if (psel && penable && pwrite) wrote_r <= 1'b1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence apbWait; psel && penable && !pready; endsequence
  sequence apbPulse; pready ##1 !pready; endsequence
  chk_apb_answer: assert property (apbWait |=> apbPulse) else $error("no ready");
  chk_err_ready: assert property (pslverr |-> pready) else $error("lone err");
  chk_done_next: assert property (accValid |=> accDone_r) else $error("no done");
  chk_done_cause: assert property (accDone_r |-> $past(accValid)) else $error("odd done");
  chk_one_answer: assert property (accDone_r |-> accGrant_r^accError_r) else $error("two");
  chk_no_stray: assert property (!accDone_r |-> !accGrant_r&&!accError_r) else $error("x");
  chk_low_admit: assert property (fresh&&initiatorTag<8 |=> accGrant_r) else $error("deny");
  chk_high_deny: assert property (fresh&&initiatorTag>=8 |=> accError_r) else $error("pass");
endmodule
bind psf_firewall psf_asserts chk (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .accValid(accValid),
  .accDone_r(accDone_r), .accGrant_r(accGrant_r), .accError_r(accError_r),
  .initiatorTag(initiatorTag));

// file: testbench/psf_firewall_tb.sv
// Self-checking bench for the firewall
`timescale 1ns/10ps
module psf_firewall_tb;
  reg         sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, go = 0, er;
  reg  [7:0]  paddr = 0;
  reg  [31:0] pwdata = 0, rd;
  reg  [3:0]  t = 0;
  wire [31:0] prdata, accAddr;
  wire [3:0]  initiatorTag;
  wire        pready, pslverr, accValid, accWrite, accDone_r, accGrant_r, accError_r;
  integer     n_mismatch = 0, n_checks = 0, cyc = 0, i;
  initial forever #2.5 sys_clk = ~sys_clk;
  psf_firewall dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .accValid(accValid), .initiatorTag(initiatorTag), .accWrite(accWrite),
    .accAddr(accAddr), .accDone_r(accDone_r), .accGrant_r(accGrant_r), .accError_r(accError_r));
  psf_initiator ini (.clk(sys_clk), .go(go), .t(t), .accValid(accValid),
    .initiatorTag(initiatorTag), .accWrite(accWrite), .accAddr(accAddr));
  task chk(input [31:0] g, e); begin
    n_checks = n_checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  end endtask
  task apb(input w, input [7:0] a, input [31:0] d); begin
    @(posedge sys_clk) psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    @(posedge sys_clk) while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  end endtask
  task acc(input [3:0] g, input e); begin
    @(posedge sys_clk) go <= 1; t <= g;
    @(posedge sys_clk) go <= 0;
    @(posedge sys_clk) #1 chk({accDone_r, accGrant_r, accError_r}, {1'b1, e, !e});
  end endtask
  task print_verdict; begin
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1;
    repeat (3) @(posedge sys_clk);
    apb(0, 8'h00, 0); chk(rd, 32'h0000ffff);
    for (i = 0; i < 13; i = i + 1) acc(i[3:0], i < 8);
    apb(0, 8'h08, 0); chk(rd, 32'h10);
    apb(0, 8'h0c, 0); chk(rd, 5);
    $display("defaults done");
    for (i = 0; i < 13; i = i + 1) begin
      apb(1, 8'h00, 32'h1 << (2 * i)); acc(i[3:0], 1);
      apb(1, 8'h00, ~(32'h1 << (2 * i))); acc(i[3:0], 0);
    end
    apb(0, 8'h04, 0); chk(rd, 32'h3); chk(er, 0);
    apb(0, 8'h0c, 0); chk(rd, 32'h12);
    apb(1, 8'h04, 1); acc(4'hc, 0); apb(0, 8'h08, 0); chk(rd, 32'h18);
    apb(0, 8'h10, 0); chk(rd, 32'hc0000000);
    apb(0, 8'h14, 0); chk({er, rd[30:0]}, 32'h80000000);
    $display("mapping done");
    rst_b <= 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1;
    repeat (3) @(posedge sys_clk);
    apb(0, 8'h00, 0); chk(rd, 32'h0000ffff);
    acc(4'h7, 1); acc(4'h8, 0);
    $display("reset done");
    print_verdict;
  end
endmodule

// file: testbench/psf_initiator.sv
// Initiator model issuing one access per request
`timescale 1ns/10ps
module psf_initiator (
  input  wire        clk,
  input  wire        go,
  input  wire [3:0]  t,
  output reg         accValid = 1'b0,
  output reg  [3:0]  initiatorTag = 4'h0,
  output reg         accWrite = 1'b0,
  output reg  [31:0] accAddr = 32'h0
);
  // Idle lines flip so a stale tag never looks valid
  always @(posedge clk) begin
    accValid <= go;
    initiatorTag <= go ? t : ~initiatorTag;
    accWrite <= go ? t[0] : ~accWrite;
    accAddr <= go ? {t, 28'h0} : ~accAddr;
  end
endmodule
